/* rtl/reset_cause_consts.svh */
`ifndef RESET_CAUSE_CONSTS_SVH
`define RESET_CAUSE_CONSTS_SVH

// register byte offsets on the bus
`define CAUSE_STATUS_OFS 12'h000
`define ABORT_STATUS_OFS 12'h004
`define SOFT_RESET_CTRL_OFS 12'h008

// implemented flag bits per register
`define CAUSE_IMPL_MASK 16'h7f80
`define ABORT_IMPL_MASK 16'he000

// cause flag positions
`define BIT_CLOCK_FAULT 14
`define BIT_WATCHDOG 13
`define BIT_ILL_MODE 12
`define BIT_ILL_ADDR 11
`define BIT_ILL_ACCESS 10
`define BIT_PERIPH 9
`define BIT_OVERLAP 8
`define BIT_SW_RESET 7

// abort flag positions
`define BIT_ABT_ADDR 15
`define BIT_ABT_MEM 14
`define BIT_ABT_PERIPH 13

// software reset control field
`define SOFT_RESET_LSB 14
`define SOFT_RESET_MSB 15
`define SOFT_RESET_IDLE 2'b01

// reset request pulse length
`define CLOCK_PERIOD_NS 25
`define RESET_PULSE_NS 100
`define RESET_PULSE_CYCLES ((`RESET_PULSE_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)

`endif

/* rtl/reset_cause_pkg.sv */
`default_nettype none
package reset_cause_pkg;
    // one-cycle event pulses from the detectors, plus the mode level
    typedef struct packed {
        logic clockFault;
        logic watchdogReset;
        logic illegalMode;
        logic illegalAddress;
        logic illegalAccess;
        logic periphViolation;
        logic mapOverlap;
        logic overlapAccess;
        logic userMode;
    } cause_events_t;

    typedef logic [15:0] flag_vec_t;
endpackage : reset_cause_pkg
`default_nettype wire

/* rtl/reset_cause_status_flags.sv */
`include "reset_cause_consts.svh"
`default_nettype none
// reset and abort cause flags behind an apb slave
module reset_cause_status_flags (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic warmReset,
    input wire reset_cause_pkg::cause_events_t events,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [2:0] pprot,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic resetRequest,
    output reset_cause_pkg::flag_vec_t causeFlags,
    output reset_cause_pkg::flag_vec_t abortFlags
);

    // bus decode

    logic setupPhase;
    logic accessDone;
    logic writeDone;
    logic hitCause;
    logic hitAbort;
    logic hitSwCtrl;
    logic hitAny;
    logic privileged;

    // setup is psel without penable; the access ends on pready
    assign setupPhase = psel && !penable;
    assign accessDone = psel && penable && pready;
    assign writeDone = accessDone && pwrite;

    // only word aligned offsets hit a register
    assign hitCause = (paddr == `CAUSE_STATUS_OFS);
    assign hitAbort = (paddr == `ABORT_STATUS_OFS);
    assign hitSwCtrl = (paddr == `SOFT_RESET_CTRL_OFS);
    assign hitAny = hitCause || hitAbort || hitSwCtrl;

    // apb4 protection bit zero marks a privileged access
    assign privileged = pprot[0];


    // byte lane mask for clears

    logic [15:0] laneMask;

    // only the two low lanes carry flags; upper lanes are reserved
    assign laneMask = {{8{pstrb[1]}}, {8{pstrb[0]}}};


    // software clear strobes, write 0 clears, write 1 keeps

    logic [15:0] causeClear;
    logic [15:0] abortClear;

    // clears are accepted in every mode
    assign causeClear = (writeDone && hitCause) ? (~pwdata[15:0] & laneMask) : 16'h0000;
    assign abortClear = (writeDone && hitAbort) ? (~pwdata[15:0] & laneMask) : 16'h0000;


    // software reset control field

    logic [1:0] swField;
    logic swCtrlWrite;
    logic swResetHit;

    assign swField = pwdata[`SOFT_RESET_MSB:`SOFT_RESET_LSB];

    // user-mode writes are dropped silently; the field always reads idle
    assign swCtrlWrite = writeDone && hitSwCtrl && privileged && pstrb[1];

    // any pattern except the idle code asks for a global reset
    assign swResetHit = swCtrlWrite && (swField != `SOFT_RESET_IDLE);


    // event qualification

    logic privAddr;
    logic privAccess;
    logic userAddr;
    logic userAccess;
    logic userPeriph;
    logic overlapHit;

    // the detectors give single-cycle pulses, so no edge detect here
    assign privAddr = events.illegalAddress && !events.userMode;
    assign privAccess = events.illegalAccess && !events.userMode;
    assign userAddr = events.illegalAddress && events.userMode;
    assign userAccess = events.illegalAccess && events.userMode;
    assign userPeriph = events.periphViolation && events.userMode;

    // overlap alone is harmless until the shared region is touched
    assign overlapHit = events.mapOverlap && events.overlapAccess;


    // set vectors

    logic [15:0] causeSet;
    logic [15:0] abortSet;

    // each cause ors into its own bit, leaving others alone
    always_comb begin
        causeSet = 16'h0000;
        causeSet[`BIT_CLOCK_FAULT] = events.clockFault;
        causeSet[`BIT_WATCHDOG] = events.watchdogReset;
        causeSet[`BIT_ILL_MODE] = events.illegalMode;
        causeSet[`BIT_ILL_ADDR] = privAddr;
        causeSet[`BIT_ILL_ACCESS] = privAccess;
        causeSet[`BIT_PERIPH] = userPeriph;
        causeSet[`BIT_OVERLAP] = overlapHit;
        causeSet[`BIT_SW_RESET] = swResetHit;
    end

    // user-mode address and access faults abort rather than reset; a user peripheral violation does both
    always_comb begin
        abortSet = 16'h0000;
        abortSet[`BIT_ABT_ADDR] = userAddr;
        abortSet[`BIT_ABT_MEM] = userAccess;
        abortSet[`BIT_ABT_PERIPH] = userPeriph;
    end


    // flag storage, one cell per implemented bit

    localparam logic [15:0] CauseMask = `CAUSE_IMPL_MASK;
    localparam logic [15:0] AbortMask = `ABORT_IMPL_MASK;

    // cause cells ignore warm reset so they outlive the reset they cause;
    // abort cells go back to zero on any reset
    genvar i;
    generate
        for (i = 0; i < 16; i = i + 1) begin : g_flag
            if (CauseMask[i]) begin : g_cause
                sticky_flag u_cause (
                    .clock(clock),
                    .sys_rst(sys_rst),
                    .warmClear(1'b0),
                    .setPulse(causeSet[i]),
                    .clearPulse(causeClear[i]),
                    .flagReg(causeFlags[i])
                );
            end else begin : g_cause_none
                assign causeFlags[i] = 1'b0;
            end
            if (AbortMask[i]) begin : g_abort
                sticky_flag u_abort (
                    .clock(clock),
                    .sys_rst(sys_rst),
                    .warmClear(warmReset),
                    .setPulse(abortSet[i]),
                    .clearPulse(abortClear[i]),
                    .flagReg(abortFlags[i])
                );
            end else begin : g_abort_none
                assign abortFlags[i] = 1'b0;
            end
        end
    endgenerate


    // reset request generation

    localparam logic [3:0] PulseCycles = 4'(`RESET_PULSE_CYCLES);

    logic resetTrigger;
    logic [3:0] pulseCnt_reg;
    logic [3:0] pulseCnt_next;
    logic resetRequest_next;

    // internally detected faults that end in a system reset;
    // clock fault and watchdog already come with their own reset
    assign resetTrigger = events.illegalMode || privAddr || privAccess || userPeriph
                          || overlapHit || swResetHit;

    // a fresh trigger reloads, so the pulse never comes out short
    assign pulseCnt_next = resetTrigger ? PulseCycles :
                           (pulseCnt_reg != 4'h0) ? pulseCnt_reg - 4'h1 : 4'h0;

    assign resetRequest_next = (pulseCnt_next != 4'h0);

    // the warm reset it produced ends the request too
    always_ff @(posedge clock) begin
        if (sys_rst || warmReset) begin
            pulseCnt_reg <= 4'h0;
            resetRequest <= 1'b0;
        end else begin
            pulseCnt_reg <= pulseCnt_next;
            resetRequest <= resetRequest_next;
        end
    end


    // read mux

    logic [31:0] readWord;
    logic [31:0] swCtrlWord;

    // the control field always reads back the idle code
    assign swCtrlWord = {16'h0000, `SOFT_RESET_IDLE, 14'h0000};

    // reserved bits read zero; reads are allowed in every mode
    assign readWord = hitCause ? {16'h0000, causeFlags} :
                      hitAbort ? {16'h0000, abortFlags} :
                      hitSwCtrl ? swCtrlWord : 32'h0000_0000;


    // bus answer registers

    logic pready_next;
    logic pslverr_next;
    logic [31:0] prdata_next;

    // ready rises for exactly the first access cycle: no wait states
    assign pready_next = setupPhase;

    // an unmapped offset completes with an error and zero data
    assign pslverr_next = setupPhase && !hitAny;

    // data is captured at a read setup and held until the next read setup
    assign prdata_next = (setupPhase && !pwrite) ? readWord : prdata;

    // answer flops
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= pready_next;
            pslverr <= pslverr_next;
            prdata <= prdata_next;
        end
    end
endmodule : reset_cause_status_flags
`default_nettype wire

/* rtl/sticky_flag.sv */
`default_nettype none
// one sticky status bit; power-up and optional warm clear, set wins over the clear pulse, warm clear wins over set
module sticky_flag (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic warmClear,
    input wire logic setPulse,
    input wire logic clearPulse,
    output logic flagReg
);
    logic flagNext;

    // set first so a clear pulse in the same cycle cannot lose an event
    assign flagNext = setPulse ? 1'b1 : (clearPulse ? 1'b0 : flagReg);

    // power-up clears; warm clear only where the owner asks for it
    always_ff @(posedge clock) begin
        if (sys_rst || warmClear) begin
            flagReg <= 1'b0;
        end else begin
            flagReg <= flagNext;
        end
    end
endmodule : sticky_flag
`default_nettype wire

/* verif/reset_cause_status_flags_props.sv */
`default_nettype none
// watches the flag bank from its ports only
module reset_cause_status_flags_props (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic warmReset,
    input wire reset_cause_pkg::cause_events_t events,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [2:0] pprot,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic resetRequest,
    input wire reset_cause_pkg::flag_vec_t causeFlags,
    input wire reset_cause_pkg::flag_vec_t abortFlags
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // a completed write to the cause register is the only way a cause flag may drop
    wire logic causeWrite = psel && penable && pwrite && pready && paddr == 12'h000;
    sequence pulse4;
        resetRequest [*4];
    endsequence
    sequence flagsKept;
        (causeFlags & $past(causeFlags)) == $past(causeFlags);
    endsequence
    chk_clock_fault_set: assert property (events.clockFault |=> causeFlags[14])
        else $error("clock fault flag not set");
    chk_mode_set_reset: assert property (events.illegalMode |=> causeFlags[12] ##0 pulse4)
        else $error("illegal mode flag or reset pulse missing");
    chk_flags_sticky: assert property (!causeWrite |=> flagsKept)
        else $error("cause flag dropped without a clear");
    chk_reserved_zero: assert property (causeFlags[15] == 1'b0 && causeFlags[6:0] == '0)
        else $error("reserved cause bits not zero");
    chk_overlap_reset: assert property (events.mapOverlap && events.overlapAccess |=> causeFlags[8] ##0 pulse4)
        else $error("overlap flag or reset pulse missing");
    chk_periph_both: assert property (events.periphViolation && events.userMode |=> causeFlags[9] && abortFlags[13])
        else $error("peripheral violation not recorded");
    chk_priv_addr: assert property (events.illegalAddress && !events.userMode |=> causeFlags[11] && resetRequest)
        else $error("privileged illegal address not recorded");
    chk_priv_access: assert property (events.illegalAccess && !events.userMode |=> causeFlags[10])
        else $error("privileged illegal access not recorded");
    chk_write_zero_clear: assert property (causeWrite && pstrb[1] && !pwdata[13] && !events.watchdogReset
        |=> !causeFlags[13])
        else $error("write of zero did not clear");
    chk_warm_abort_clear: assert property (warmReset && !events.illegalAddress && !events.illegalAccess
        && !events.periphViolation |=> abortFlags == 16'h0000)
        else $error("warm reset left abort flags");
endmodule : reset_cause_status_flags_props
`default_nettype wire

/* verif/test_reset_cause_status_flags.sv */
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
    $display("[ERR] %0t got %h want %h", $time, g, e); end end
module test_reset_cause_status_flags;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock, sys_rst, warmReset, psel, penable, pwrite, pready, pslverr, resetRequest, err;
    reset_cause_pkg::cause_events_t events;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, exp;
    logic [3:0] pstrb;
    logic [2:0] pprot;
    reset_cause_pkg::flag_vec_t causeFlags, abortFlags;
    int bad_count, comparisons;
    reset_cause_status_flags uut (.clock, .sys_rst, .warmReset, .events, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .pprot, .prdata, .pready, .pslverr, .resetRequest, .causeFlags, .abortFlags);
    // free-running 40 MHz clock
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    task final_report;
        if (bad_count == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : final_report
    // one apb transfer; ev pulses into the access phase so it lands on the write edge
    task automatic apb(input logic [11:0] a, input logic [31:0] d, input logic wr,
            input reset_cause_pkg::cause_events_t ev);
        int n;
        n = 0;
        psel <= 1'b1;
        paddr <= a;
        pwdata <= d;
        pwrite <= wr;
        @(posedge clock);
        penable <= 1'b1;
        events <= ev;
        do begin
            @(posedge clock);
            events <= '0;
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            bad_count++;
            final_report();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask : apb
    task automatic pulse(input reset_cause_pkg::cause_events_t ev);
        events <= ev;
        @(posedge clock);
        events <= '0;
        @(posedge clock);
    endtask : pulse
    task sc_causes;
        reset_cause_pkg::cause_events_t evs [7];
        int bits [7];
        evs = '{9'h100, 9'h080, 9'h040, 9'h020, 9'h010, 9'h009, 9'h006};
        bits = '{14, 13, 12, 11, 10, 9, 8};
        exp = '0;
        apb(12'h008, '0, 1'b0, '0);
        `CHK(rd, 32'h0000_4000)
        for (int i = 0; i < 7; i++) begin
            pulse(evs[i]);
            exp[bits[i]] = 1'b1;
            apb(12'h000, '0, 1'b0, '0);
            `CHK(rd, exp)
        end
        pprot <= 3'h0;
        apb(12'h008, '0, 1'b1, '0);
        pprot <= 3'h1;
        apb(12'h008, '0, 1'b1, '0);
        exp[7] = 1'b1;
        apb(12'h000, '0, 1'b0, '0);
        `CHK(rd, exp)
    endtask : sc_causes
    task sc_clears;
        apb(12'h000, 32'hffff_ffff, 1'b1, '0);
        apb(12'h000, '0, 1'b0, '0);
        `CHK(rd, exp)
        apb(12'h000, ~32'h0000_2000, 1'b1, '0);
        apb(12'h000, ~32'h0000_1000, 1'b1, 9'h040);
        exp[13] = 1'b0;
        apb(12'h000, '0, 1'b0, '0);
        `CHK(rd, exp)
        apb(12'h0f0, '0, 1'b0, '0);
        `CHK(err, 1'b1)
    endtask : sc_clears
    task sc_resets;
        warmReset <= 1'b1;
        @(posedge clock);
        warmReset <= 1'b0;
        apb(12'h000, '0, 1'b0, '0);
        `CHK(rd, exp)
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        apb(12'h000, '0, 1'b0, '0);
        `CHK(rd, 32'h0000_0000)
    endtask : sc_resets
    task sc_aborts;
        pulse(9'h021);
        `CHK(resetRequest, 1'b0)
        pulse(9'h011);
        apb(12'h004, '0, 1'b0, '0);
        `CHK(rd, 32'h0000_c000)
        apb(12'h004, ~32'h0000_8000, 1'b1, '0);
        apb(12'h004, '0, 1'b0, '0);
        `CHK(rd, 32'h0000_4000)
        warmReset <= 1'b1;
        @(posedge clock);
        warmReset <= 1'b0;
        apb(12'h004, '0, 1'b0, '0);
        `CHK(rd, 32'h0000_0000)
    endtask : sc_aborts
    // main sequence
    initial begin
        sys_rst = 1'b1;
        warmReset = 1'b0;
        events = '0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'hf;
        pprot = 3'h1;
        bad_count = 0;
        comparisons = 0;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        sc_causes();
        sc_clears();
        sc_resets();
        sc_aborts();
        final_report();
    end
endmodule : test_reset_cause_status_flags
bind reset_cause_status_flags reset_cause_status_flags_props chk (.clock, .sys_rst, .warmReset, .events, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pstrb, .pprot, .prdata, .pready, .pslverr, .resetRequest, .causeFlags,
    .abortFlags);
`default_nettype wire
